// [cpu_host.sv]
// Purpose: CPU side reader of the flash
// Assumes: One read is a single rd_en strobe
// Notes: Address is inverted once released so stale values never look valid
`timescale 1ns/1ps
module cpu_host (
  input wire logic clk,
  input wire logic [15:0] rd_data,
  output logic rd_en,
  output logic [17:0] rd_addr
);
  initial begin
    rd_en = 1'b0;
    rd_addr = '0;
  end
  // Status is read at the word programmed or inside the erased block
  task automatic read_word(input logic [17:0] a, output logic [15:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    @(posedge clk);
    #1;
    d = rd_data;
  endtask
endmodule

// [flash_cycle_timer.sv]
// Purpose: Down counter for the erase window and the protected-block hold
// Assumes: Load and count are synchronous; load wins
// Notes: Expired is a one-cycle pulse when the count reaches zero
`timescale 1ns/1ps
module flash_cycle_timer
  import flash_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic run,
  output logic expired
);

  logic [15:0] count_q;
  logic [15:0] count_d;
  logic expired_d;

  assign expired_d = run && !load && (count_q == 16'h0001);
  assign count_d = load ? load_value :
                   (run && count_q != 16'h0000) ? count_q - 16'h0001 : count_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 16'h0000;
      expired <= 1'b0;
    end else begin
      count_q <= count_d;
      expired <= expired_d;
    end
  end

endmodule

// [flash_status_pkg.sv]
// Purpose: Shared constants and types for the flash status reporting block
// Assumes: 50 MHz system clock, asynchronous active-low reset
// Notes: Status word bit positions and timing counts live here
package flash_status_pkg;

  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned ERASE_WINDOW_US = 96;
  localparam int unsigned PROT_POLL_US = 100;
  localparam int unsigned ERASE_WINDOW_CYC = ERASE_WINDOW_US * CLK_MHZ;
  localparam int unsigned PROT_POLL_CYC = PROT_POLL_US * CLK_MHZ;

  localparam int DATA_POLL_POS = 7;
  localparam int TOGGLE_A_POS = 6;
  localparam int ERROR_POS = 5;
  localparam int TIMEOUT_POS = 3;
  localparam int TOGGLE_B_POS = 2;

  localparam logic [7:0] READ_RESET_CODE = 8'hf0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ERASE_WAIT = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROGRAM = 3'b011,
    ST_SUSPEND = 3'b100,
    ST_SUSP_PROG = 3'b101,
    ST_PROT_HOLD = 3'b110,
    ST_ERR_DONE = 3'b111
  } engine_state_t;

  // Events decoded by the neighbouring command interface, one-cycle pulses
  typedef struct packed {
    logic program_start;
    logic erase_confirm;
    logic chip_erase;
    logic all_protected;
    logic suspend;
    logic resume;
    logic read_reset;
  } cmd_event_t;

  // Completion reports from the array timing logic
  typedef struct packed {
    logic prog_done;
    logic erase_done;
    logic fail;
  } array_report_t;

endpackage

// [flash_status_props.sv]
// Purpose: Port assertions for flash status reporting
// Assumes: Outputs lag the engine state by one clock
// Notes: quiet_q says no event came last cycle, so the state is settled
`timescale 1ns/1ps
module flash_status_props
  import flash_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire cmd_event_t cmd,
  input wire array_report_t report,
  input wire logic rd_en,
  input wire logic [15:0] array_data,
  input wire logic [15:0] rd_data,
  input wire logic ready_busy_n,
  input wire logic busy_irq_pulse,
  input wire logic engine_active,
  input wire logic cmd_refused
);
  logic quiet_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      quiet_q <= 1'b0;
    else
      quiet_q <= (cmd == '0) && (report == '0);
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_accept;
    !cmd_refused ##1 ready_busy_n;
  endsequence
  sequence s_go_ready;
    ##2 !ready_busy_n;
  endsequence
  property p_refuse;
    quiet_q && ready_busy_n && cmd.program_start |=> cmd_refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("program taken while busy");
  property p_accept;
    quiet_q && !ready_busy_n && !engine_active && cmd.program_start |=> s_accept;
  endproperty
  a_accept: assert property (p_accept) else $error("idle program not started");
  property p_done;
    quiet_q && ready_busy_n && engine_active && report.prog_done |-> s_go_ready;
  endproperty
  a_done: assert property (p_done) else $error("busy stays after done");
  property p_irq;
    busy_irq_pulse |-> $fell(ready_busy_n) ##1 !busy_irq_pulse;
  endproperty
  a_irq: assert property (p_irq) else $error("ready pulse not on busy fall");
  property p_reserved;
    rd_en && quiet_q |=> engine_active |-> (rd_data & 16'hff13) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bit set");
  property p_hold;
    !rd_en |=> $stable(rd_data);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_array;
    // Engine_active one cycle after the read tells what that read returned
    rd_en && quiet_q && !ready_busy_n |=> !engine_active |-> rd_data == $past(array_data);
  endproperty
  a_array: assert property (p_array) else $error("idle read not array data");
  property p_reset_cmd;
    quiet_q && cmd.read_reset && report == '0 |-> ##2 !engine_active;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored");
  property p_suspend;
    quiet_q && ready_busy_n && cmd.suspend |-> s_go_ready;
  endproperty
  a_suspend: assert property (p_suspend) else $error("busy during suspend");
endmodule

// [flash_status_reporting.sv]
// Purpose: Ready/busy line and status word for the flash erase/program engine
// Assumes: Command events come decoded; CPU reads are single-cycle strobes
// Notes: Read data is registered, valid one cycle after rd_en
`timescale 1ns/1ps
module flash_status_reporting
  import flash_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire cmd_event_t cmd,
  input wire logic [17:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic [15:0] stored_data,
  input wire logic [17:0] block_base,
  input wire logic [17:0] block_mask,
  input wire array_report_t report,
  input wire logic rd_en,
  input wire logic [17:0] rd_addr,
  input wire logic [15:0] array_data,
  output logic [15:0] rd_data,
  output logic ready_busy_n,
  output logic busy_irq_pulse,
  output logic engine_active,
  output logic cmd_refused
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  engine_state_t state_q;
  engine_state_t state_d;
  logic [15:0] prog_word_q;
  logic [17:0] prog_addr_q;
  logic [17:0] erase_base_q;
  logic [17:0] erase_mask_q;
  logic erase_done_bit_q;
  logic toggle_a_q;
  logic toggle_b_q;
  logic error_q;
  logic timeout_q;
  logic last_was_erase_q;
  logic [15:0] last_prog_q;
  logic window_exp;
  logic prot_exp;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire running = (state_q == ST_ERASE) || (state_q == ST_PROGRAM) ||
                 (state_q == ST_ERASE_WAIT) || (state_q == ST_SUSP_PROG);
  wire in_suspend = (state_q == ST_SUSPEND) || (state_q == ST_SUSP_PROG);
  wire in_erase_blk = ((rd_addr & erase_mask_q) == erase_base_q);
  wire at_prog_addr = (rd_addr == prog_addr_q);
  // Busy reads come back as status; idle, and suspend outside the erased block, read the array
  wire show_status = running || (state_q == ST_PROT_HOLD) ||
                     (state_q == ST_ERR_DONE && in_erase_blk) ||
                     (state_q == ST_SUSPEND && in_erase_blk);
  wire status_read = rd_en && show_status;
  wire erasing = (state_q == ST_ERASE);
  // New program only accepted when idle or from suspend; erase only when idle or in the erase window
  wire prog_ok = (state_q == ST_IDLE) || (state_q == ST_SUSPEND);
  wire erase_ok = (state_q == ST_IDLE) || (state_q == ST_ERASE_WAIT);
  wire prog_go = cmd.program_start && prog_ok;
  wire erase_go = (cmd.erase_confirm || cmd.chip_erase) && erase_ok;
  wire refused_d = (cmd.program_start && !prog_ok) ||
                   ((cmd.erase_confirm || cmd.chip_erase) && !erase_ok);
  wire zero_to_one = |(cmd_data & ~stored_data);
  wire fail_ev = (report.fail && running) || (prog_go && zero_to_one);

  ////////////////////////////////////////////////////////////////////////////
  // Engine sequence

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (prog_go && zero_to_one) begin
          state_d = ST_ERR_DONE;
        end else if (prog_go) begin
          state_d = ST_PROGRAM;
        end else if (erase_go && cmd.all_protected) begin
          state_d = ST_PROT_HOLD;
        end else if (erase_go) begin
          state_d = ST_ERASE_WAIT;
        end
      end
      ST_ERASE_WAIT: begin
        if (cmd.suspend) begin
          state_d = ST_SUSPEND;
        end else if (window_exp) begin
          state_d = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (report.fail) begin
          state_d = ST_ERR_DONE;
        end else if (report.erase_done) begin
          state_d = ST_IDLE;
        end else if (cmd.suspend) begin
          state_d = ST_SUSPEND;
        end
      end
      ST_PROGRAM: begin
        if (report.fail) begin
          state_d = ST_ERR_DONE;
        end else if (report.prog_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_SUSPEND: begin
        if (cmd.resume) begin
          state_d = ST_ERASE;
        end else if (prog_go) begin
          state_d = ST_SUSP_PROG;
        end
      end
      ST_SUSP_PROG: begin
        if (report.prog_done || report.fail) begin
          state_d = ST_SUSPEND;
        end
      end
      ST_PROT_HOLD: begin
        if (prot_exp) begin
          state_d = ST_IDLE;
        end
      end
      ST_ERR_DONE: begin
        state_d = ST_ERR_DONE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Read/reset aborts everything but suspend, which it leaves in place, and returns to idle
    if (cmd.read_reset) begin
      state_d = (state_q == ST_SUSPEND) ? ST_SUSPEND : ST_IDLE;
    end
  end

  flash_cycle_timer u_window (
    .clk(clk),
    .rst_n(rst_n),
    .load(erase_go),
    .load_value(erase_go && cmd.all_protected ? 16'(PROT_POLL_CYC) : 16'(ERASE_WINDOW_CYC)),
    .run((state_q == ST_ERASE_WAIT) || (state_q == ST_PROT_HOLD)),
    .expired(window_exp)
  );

  assign prot_exp = window_exp && (state_q == ST_PROT_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // Status word assembly

  logic [15:0] status_word;
  logic poll_bit;
  logic tog_a_bit;
  logic tog_b_bit;
  logic err_bit;

  always_comb begin
    poll_bit = 1'b0;
    case (state_q)
      ST_PROGRAM, ST_SUSP_PROG: poll_bit = ~prog_word_q[7];
      ST_ERASE, ST_ERASE_WAIT, ST_PROT_HOLD: poll_bit = 1'b0;
      ST_SUSPEND: poll_bit = 1'b1;
      ST_ERR_DONE: poll_bit = erase_done_bit_q;
      default: poll_bit = 1'b0;
    endcase
  end

  // Suspended-block reads give toggle A as 1
  assign tog_a_bit = (state_q == ST_SUSPEND && in_erase_blk) ? 1'b1 : toggle_a_q;
  assign tog_b_bit = (state_q == ST_SUSP_PROG && at_prog_addr) ? 1'b1 : toggle_b_q;
  // Success shows 0 while running; errors latch until read/reset
  assign err_bit = error_q;

  always_comb begin
    status_word = STATUS_RESET;
    status_word[DATA_POLL_POS] = poll_bit;
    status_word[TOGGLE_A_POS] = tog_a_bit;
    status_word[ERROR_POS] = err_bit;
    status_word[TIMEOUT_POS] = timeout_q;
    status_word[TOGGLE_B_POS] = tog_b_bit;
  end

  // After a good finish the array holds the last word, or ffff after erase
  wire [15:0] read_value = show_status ? status_word : array_data;

  ////////////////////////////////////////////////////////////////////////////
  // Flag updates

  wire tog_a_flip = (status_read && (running || state_q == ST_PROT_HOLD)) ||
                    (cmd.suspend && erasing) || (cmd.resume && in_suspend);
  wire tog_b_flip = (status_read && (erasing || state_q == ST_ERASE_WAIT)) ||
                    (status_read && state_q == ST_SUSPEND && in_erase_blk) ||
                    (prog_go && in_suspend && ((cmd_addr & erase_mask_q) == erase_base_q)) ||
                    (status_read && state_q == ST_ERR_DONE && in_erase_blk);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      prog_word_q <= 16'h0000;
      prog_addr_q <= 18'h00000;
      erase_base_q <= 18'h00000;
      erase_mask_q <= 18'h3ffff;
      erase_done_bit_q <= 1'b0;
      last_was_erase_q <= 1'b0;
      last_prog_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (prog_go) begin
        prog_word_q <= cmd_data;
        prog_addr_q <= cmd_addr;
        last_was_erase_q <= 1'b0;
      end
      if (erase_go && state_q == ST_IDLE) begin
        erase_base_q <= cmd.chip_erase ? 18'h00000 : block_base;
        erase_mask_q <= cmd.chip_erase ? 18'h00000 : block_mask;
        last_was_erase_q <= 1'b1;
      end
      if (report.prog_done) begin
        last_prog_q <= prog_word_q;
      end
      if (state_q == ST_PROGRAM || state_q == ST_SUSP_PROG) begin
        erase_done_bit_q <= ~prog_word_q[7];
      end else if (state_q == ST_ERASE) begin
        erase_done_bit_q <= report.erase_done;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_a_q <= 1'b0;
      toggle_b_q <= 1'b0;
      error_q <= 1'b0;
      timeout_q <= 1'b1;
    end else begin
      toggle_a_q <= toggle_a_q ^ tog_a_flip;
      toggle_b_q <= toggle_b_q ^ tog_b_flip;
      // Failure beats a simultaneous read/reset so no event is lost
      if (fail_ev) begin
        error_q <= 1'b1;
      end else if (cmd.read_reset) begin
        error_q <= 1'b0;
      end
      if (erase_go && !cmd.all_protected) begin
        timeout_q <= 1'b0;
      end else if (window_exp || cmd.suspend) begin
        timeout_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Busy excludes suspend so a program into another block can be issued
  wire busy_d = running || (state_q == ST_PROT_HOLD);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
      ready_busy_n <= 1'b0;
      busy_irq_pulse <= 1'b0;
      engine_active <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      rd_data <= rd_en ? read_value : rd_data;
      ready_busy_n <= busy_d;
      busy_irq_pulse <= ready_busy_n && !busy_d;
      engine_active <= show_status;
      cmd_refused <= refused_d;
    end
  end

endmodule

// [tb_top.sv]
// Purpose: Self-checking bench for flash status reporting
// Assumes: Events come as one-cycle pulses
// Notes: Window and hold counts are fixed 4800 and 5000 cycles
`timescale 1ns/1ps
module tb_top;
  import flash_status_pkg::*;
  localparam cmd_event_t PROG = 7'h40, ERASE = 7'h20, PROT = 7'h08;
  localparam cmd_event_t SUSP = 7'h04, RESUME = 7'h02, RRST = 7'h01;
  logic clk, rst_n, rd_en, ready_busy_n, busy_irq_pulse, engine_active, cmd_refused;
  cmd_event_t cmd;
  array_report_t report;
  logic [17:0] cmd_addr, block_base, block_mask, rd_addr;
  logic [15:0] cmd_data, stored_data, array_data, rd_data, s;
  logic [15:0] hist[$];
  int bad_count = 0;
  int check_count = 0;
  flash_status_reporting i_flash_status_reporting (.clk(clk), .rst_n(rst_n), .cmd(cmd),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .stored_data(stored_data),
    .block_base(block_base), .block_mask(block_mask), .report(report), .rd_en(rd_en),
    .rd_addr(rd_addr), .array_data(array_data), .rd_data(rd_data),
    .ready_busy_n(ready_busy_n), .busy_irq_pulse(busy_irq_pulse),
    .engine_active(engine_active), .cmd_refused(cmd_refused));
  cpu_host i_cpu_host (.clk(clk), .rd_data(rd_data), .rd_en(rd_en), .rd_addr(rd_addr));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] st(input logic poll, input logic err, input logic tmo);
    st = {8'h00, poll, 1'b0, err, 1'b0, tmo, 3'b000};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic ev(input cmd_event_t e, input array_report_t r);
    @(posedge clk);
    cmd <= e;
    report <= r;
    @(posedge clk);
    cmd <= '0;
    report <= '0;
    #1;
  endtask
  task automatic rd();
    i_cpu_host.read_word(cmd_addr, s);
    hist.push_back(s);
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1000000;
    bad_count++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    cmd = '0;
    report = '0;
    {cmd_addr, cmd_data, block_base, array_data} = '0;
    stored_data = 16'hffff;
    block_mask = 18'h30000;
    void'($urandom(23));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk({12'h000, ready_busy_n, busy_irq_pulse, engine_active, cmd_refused}, 16'h0000);
    @(posedge clk);
    cmd_addr <= 18'($urandom);
    cmd_data <= 16'($urandom);
    array_data <= 16'($urandom);
    ev(PROG, '0);
    chk({15'h0, cmd_refused}, 16'h0000);
    settle();
    chk({15'h0, ready_busy_n}, 16'h0001);
    rd();
    chk(s & 16'hffbb, st(~cmd_data[7], 1'b0, 1'b1));
    rd();
    chk({15'h0, s[6]}, {15'h0, ~hist[$-1][6]});
    ev(PROG, '0);
    chk({15'h0, cmd_refused}, 16'h0001);
    ev('0, 3'h4);
    settle();
    chk({14'h0, ready_busy_n, busy_irq_pulse}, 16'h0001);
    rd();
    chk(s, array_data);
    block_base <= cmd_addr & 18'h30000;
    ev(ERASE, '0);
    settle();
    rd();
    chk(s & 16'h0008, 16'h0000);
    repeat (4800) @(posedge clk);
    rd();
    chk(s & 16'hffbb, st(1'b0, 1'b0, 1'b1));
    rd();
    chk({14'h0, s[6], s[2]}, {14'h0, ~hist[$-1][6], ~hist[$-1][2]});
    ev(SUSP, '0);
    settle();
    chk({15'h0, ready_busy_n}, 16'h0000);
    ev(RESUME, '0);
    settle();
    chk({15'h0, ready_busy_n}, 16'h0001);
    ev('0, 3'h1);
    rd();
    chk(s & 16'h0020, 16'h0020);
    repeat (20) @(posedge clk);
    rd();
    chk(s & 16'h0020, 16'h0020);
    ev(RRST, '0);
    settle();
    rd();
    chk(s, array_data);
    ev(ERASE | PROT, '0);
    settle();
    rd();
    chk(s & 16'h0080, 16'h0000);
    repeat (5000) @(posedge clk);
    rd();
    chk(s, array_data);
    wrap_up();
  end
endmodule
bind flash_status_reporting flash_status_props i_flash_status_props (.clk(clk), .rst_n(rst_n),
  .cmd(cmd), .report(report), .rd_en(rd_en), .array_data(array_data), .rd_data(rd_data),
  .ready_busy_n(ready_busy_n), .busy_irq_pulse(busy_irq_pulse),
  .engine_active(engine_active), .cmd_refused(cmd_refused));
